// ### ict_cfg.svh
// Purpose: Shared constants for the icache data array test port
// Assumes: 512-byte cache configuration, 40 MHz aclk
// Notes: Counts are in aclk cycles
`ifndef ICT_CFG_SVH
`define ICT_CFG_SVH
// ==========================================
// Array geometry
`define ICT_DATA_DEPTH 128
`define ICT_TAG_DEPTH 32
// ==========================================
// Test-mode entry timing
`define ICT_MRST_CYC 4'h6
`define ICT_STALL_CYC 4'h8
// ==========================================
// Sequence timing, cycle numbers counted from 1
`define ICT_WR_FIRST 16'h0003
`define ICT_RD_FIRST 16'h0004
`define ICT_OE_FIRST 16'h0005
`define ICT_RD_LAT 16'h0005
// ==========================================
// Controller register offsets
`define ICT_REG_CTRL 8'h00
`define ICT_REG_ADDR 8'h04
`define ICT_REG_COUNT 8'h08
`define ICT_REG_PAT 8'h0C
`define ICT_REG_STAT 8'h10
`define ICT_REG_ERR 8'h14
`define ICT_REG_HITS 8'h18
`define ICT_REG_LAST 8'h1C
// ==========================================
// AXI responses
`define ICT_RESP_OKAY 2'h0
`define ICT_RESP_SLVERR 2'h2
`endif

// ### ict_pkg.sv
// Purpose: Types for the icache data array test port
// Assumes: Constants come from ict_cfg.svh
// Notes: Operation codes are the CTRL register op field
package ict_pkg;
    // ==========================================
    // Controller states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RST = 4'h2,
        ST_STALL = 4'h4,
        ST_RUN = 4'h8
    } ict_state_e;
    // ==========================================
    // Test sequences
    typedef enum logic [2:0] {
        OP_WRITE = 3'h0,
        OP_READ = 3'h1,
        OP_INTER = 3'h2,
        OP_KTA = 3'h3,
        OP_TAGWR = 3'h4,
        OP_ENTER = 3'h5
    } ict_op_e;
endpackage

// ### ict_if.sv
// Purpose: Test bus between memory test controller and device
// Assumes: Both ends clocked by the same aclk
// Notes: All signals change only after a rising edge
`timescale 1ns/1ps
interface ict_if;
    logic [12:0] test_addr;
    logic seq_ctrl;
    logic [31:0] test_write_data_bus;
    logic data_array_write_strobe;
    logic tag_write_strobe;
    logic data_array_read_strobe;
    logic tag_compare_strobe;
    logic read_output_enable;
    logic test_mode_select;
    logic integrated_memory_enable;
    logic write_inhibit;
    logic trace_select;
    logic master_reset_n;
    logic [31:0] test_read_data_bus;
    logic hit_flag;
    modport dev (
        input test_addr, seq_ctrl, test_write_data_bus, data_array_write_strobe,
        input tag_write_strobe, data_array_read_strobe, tag_compare_strobe,
        input read_output_enable, test_mode_select, integrated_memory_enable,
        input write_inhibit, trace_select, master_reset_n,
        output test_read_data_bus, hit_flag
    );
    modport ctl (
        output test_addr, seq_ctrl, test_write_data_bus, data_array_write_strobe,
        output tag_write_strobe, data_array_read_strobe, tag_compare_strobe,
        output read_output_enable, test_mode_select, integrated_memory_enable,
        output write_inhibit, trace_select, master_reset_n,
        input test_read_data_bus, hit_flag
    );
endinterface

// ### ict_dev.sv
// Purpose: Device end, icache data and tag arrays behind the test bus
// Assumes: Controller keeps the sequence timing on the test bus
// Notes: 128x32 data array, 32x24 tag array (23 tag bits plus valid)
`timescale 1ns/1ps
`include "ict_cfg.svh"
module ict_dev (
    input wire logic aclk,
    input wire logic aresetn,
    ict_if.dev bus
);
    logic [12:0] a1_q, a2_q, a3_q;
    logic [31:0] d1_q, d2_q, rdata_q, out_q;
    logic wr1_q, tw1_q, hit_q;
    logic [3:0] lo_q, st_q;
    logic [`ICT_TAG_DEPTH-1:0] valid_q;
    logic [31:0] dmem [0:`ICT_DATA_DEPTH-1];
    logic [22:0] tmem [0:`ICT_TAG_DEPTH-1];

    // ==========================================
    // Decode
    // Array indices from the address taken three cycles back
    wire [6:0] data_idx = a3_q[6:0];
    wire [4:0] tag_idx = a3_q[6:2];
    // Tag value: write-data upper bits with address bits above the index
    wire [22:0] exp_tag = {d2_q[31:15], a3_q[12:7]};
    wire tag_match = valid_q[tag_idx] && (tmem[tag_idx] == exp_tag);
    wire ready = (st_q == `ICT_STALL_CYC);
    wire active = bus.test_mode_select && bus.integrated_memory_enable &&
                  !bus.trace_select && ready;
    wire wr_ok = active && !bus.write_inhibit;
    wire rd_now = active && bus.data_array_read_strobe;
    wire kta_now = rd_now && bus.tag_compare_strobe;

    assign bus.test_read_data_bus = out_q;
    assign bus.hit_flag = hit_q;

    // ==========================================
    // Test-mode entry tracking
    // Low time of master reset, then settle count after release
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lo_q <= 4'h0;
            st_q <= 4'h0;
        end else if (!bus.master_reset_n) begin
            st_q <= 4'h0;
            if (lo_q != `ICT_MRST_CYC) begin
                lo_q <= lo_q + 4'h1;
            end
        end else begin
            lo_q <= 4'h0;
            if ((lo_q == `ICT_MRST_CYC || st_q != 4'h0) && st_q != `ICT_STALL_CYC) begin
                st_q <= st_q + 4'h1;
            end
        end
    end

    // ==========================================
    // Input pipeline
    // Address, write data and write strobes captured on the rising edge
    always_ff @(posedge aclk) begin
        if (!aresetn || !bus.master_reset_n) begin
            a1_q <= 13'h0000;
            a2_q <= 13'h0000;
            a3_q <= 13'h0000;
            d1_q <= 32'h0000_0000;
            d2_q <= 32'h0000_0000;
            wr1_q <= 1'b0;
            tw1_q <= 1'b0;
        end else begin
            a1_q <= bus.test_addr;
            a2_q <= a1_q;
            a3_q <= a2_q;
            d1_q <= bus.test_write_data_bus;
            d2_q <= d1_q;
            wr1_q <= wr_ok && bus.data_array_write_strobe;
            tw1_q <= wr_ok && bus.tag_write_strobe;
        end
    end

    // ==========================================
    // Array writes
    // Strobe from the previous cycle writes in the following one
    always_ff @(posedge aclk) begin
        if (wr1_q) begin
            dmem[data_idx] <= d2_q;
        end
        if (tw1_q) begin
            tmem[tag_idx] <= exp_tag;
        end
    end

    // Valid bit per tag entry
    genvar gi;
    generate
        for (gi = 0; gi < `ICT_TAG_DEPTH; gi = gi + 1) begin : g_valid
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    valid_q[gi] <= 1'b0;
                end else if (tw1_q && tag_idx == 5'(gi)) begin
                    valid_q[gi] <= 1'b1;
                end
            end
        end
    endgenerate

    // ==========================================
    // Array reads and output stage
    // Read at strobe edge, output one cycle later: five after address
    always_ff @(posedge aclk) begin
        if (!aresetn || !bus.master_reset_n) begin
            rdata_q <= 32'h0000_0000;
            out_q <= 32'h0000_0000;
            hit_q <= 1'b0;
        end else begin
            if (rd_now) begin
                // Miss in compare mode returns zero
                rdata_q <= (kta_now && !tag_match) ? 32'h0 : dmem[data_idx];
            end
            hit_q <= kta_now && tag_match;
            if (active && bus.read_output_enable) begin
                out_q <= rdata_q;
            end
        end
    end
endmodule

// ### ict_ctl.sv
// Purpose: Test controller end, drives test sequences from AXI4-Lite orders
// Assumes: Device keeps its fixed pipeline latencies
// Notes: Data pattern for word i is PAT + i; address is ADDR + i
// Behaviour
// - Enter test mode: reset six, wait eight
// - Every data longword addressable through test bus
// - Sample inputs, change outputs on rising edge
// - Write: address cycle one, data cycle two
// - Write strobe from cycle three, write cycle four
// - Write data belongs to previous cycle address
// - Read: address each cycle, read strobe cycle four
// - Output enable from cycle five, hold strobe
// - Read data five cycles after address
// - Five idle cycles after last read address
// - Interleaved: A1 strobe, A1/D1, then A2
// - Interleaved cycle four: D2, read, strobe off
// - Interleaved cycle five: A3, output, strobe on
// - Then alternate write and read cycles
// - Compare mode checks valid and tag bits
// - Load tag and data arrays before compare
// - 512-byte cache array sizes and index bits
// - Tag value is data bits plus upper address
// - Compare mode: expected tag in cycle two
// - Compare and read strobes in cycle four
// - Output enable from five, hold both strobes
`timescale 1ns/1ps
`include "ict_cfg.svh"
module ict_ctl (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    ict_if.ctl bus
);
    ict_pkg::ict_state_e st_q, st_d;
    ict_pkg::ict_op_e op_q;
    logic [15:0] c_q, c_d, n_q;
    logic [12:0] base_q, addr_q;
    logic [31:0] pat_q, err_q, hits_q, last_q, wd_q, data_q, rd_q;
    logic [7:0] wa_q;
    logic awh_q, wh_q, bv_q, rv_q, done_q, rdy_q, mrst_q;
    logic [1:0] br_q, rr_q;
    logic [3:0] cnt_q, ws_q;
    logic seq_q, wr_q, tw_q, rs_q, kta_q, oe_q;

    // ==========================================
    // Helpers
    function automatic logic in_rng(input logic [15:0] c, input logic [15:0] lo,
                                    input logic [15:0] hi);
        in_rng = (c >= lo) && (c <= hi);
    endfunction

    // Byte-lane merge for register writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge = (old & ~m) | (wd & m);
    endfunction

    // ==========================================
    // AXI4-Lite decode
    wire do_wr = awh_q && wh_q && !bv_q;
    wire [7:0] wofs = {wa_q[7:2], 2'h0};
    wire [7:0] rofs = {s_axi_araddr[7:2], 2'h0};
    wire w_map = (wofs <= `ICT_REG_LAST);
    wire r_map = (rofs <= `ICT_REG_LAST);
    wire [31:0] ctl_wd = merge(32'h0000_0000, wd_q, ws_q);
    wire op_ok = (ctl_wd[2:0] <= 3'h5);
    wire start = do_wr && wofs == `ICT_REG_CTRL && st_q == ict_pkg::ST_IDLE && op_ok;
    wire busy = (st_q != ict_pkg::ST_IDLE);
    assign s_axi_awready = !awh_q && !bv_q;
    assign s_axi_wready = !wh_q && !bv_q;
    assign s_axi_arready = !rv_q;
    assign s_axi_bvalid = bv_q;
    assign s_axi_bresp = br_q;
    assign s_axi_rvalid = rv_q;
    assign s_axi_rresp = rr_q;
    assign s_axi_rdata = rd_q;
    wire [31:0] rmux = (rofs == `ICT_REG_CTRL) ? {29'h0, op_q} :
                       (rofs == `ICT_REG_ADDR) ? {19'h0, base_q} :
                       (rofs == `ICT_REG_COUNT) ? {16'h0, n_q} :
                       (rofs == `ICT_REG_PAT) ? pat_q :
                       (rofs == `ICT_REG_STAT) ? {29'h0, done_q, rdy_q, busy} :
                       (rofs == `ICT_REG_ERR) ? err_q :
                       (rofs == `ICT_REG_HITS) ? hits_q :
                       (rofs == `ICT_REG_LAST) ? last_q : 32'h0000_0000;

    // ==========================================
    // Sequence schedule for the next cycle
    wire is_int = (op_q == ict_pkg::OP_INTER);
    wire is_kta = (op_q == ict_pkg::OP_KTA);
    wire is_rd = (op_q == ict_pkg::OP_READ) || is_kta;
    wire [15:0] n2 = 16'(n_q << 1);
    wire [15:0] last = is_int ? 16'(n2 + `ICT_RD_LAT) :
                       is_rd ? 16'(n_q + `ICT_RD_LAT) : 16'(n_q + `ICT_WR_FIRST);
    wire [15:0] cn = c_d;
    // Interleaved: each address stands two cycles, data one cycle behind
    wire [15:0] ai = is_int ? 16'((cn - 16'h0001) >> 1) : 16'(cn - 16'h0001);
    wire [15:0] di = is_int ? 16'((cn >> 1) - 16'h0001) : 16'(cn - 16'h0002);
    wire a_ok = is_int ? in_rng(cn, 16'h0001, n2) : in_rng(cn, 16'h0001, n_q);
    wire d_ok = is_int ? in_rng(cn, 16'h0002, 16'(n2 + 16'h0001)) :
                         in_rng(cn, 16'h0002, 16'(n_q + 16'h0001));
    wire lin_ws = in_rng(cn, `ICT_WR_FIRST, 16'(n_q + 16'h0002));
    // Strobe off in the read cycle, on in the write cycle
    wire int_ws = (cn[0] || cn == 16'h0002) && cn <= 16'(n2 + 16'h0001);
    wire nx_wr = is_int ? int_ws : (op_q == ict_pkg::OP_WRITE) && lin_ws;
    wire nx_tw = (op_q == ict_pkg::OP_TAGWR) && lin_ws;
    wire nx_rs = is_int ? in_rng(cn, `ICT_RD_FIRST, last) :
                 is_rd && in_rng(cn, `ICT_RD_FIRST, 16'(n_q + 16'h0003));
    wire nx_kta = is_kta && in_rng(cn, `ICT_RD_FIRST, 16'(n_q + 16'h0003));
    wire nx_oe = is_int ? in_rng(cn, `ICT_OE_FIRST, last) :
                 is_rd && in_rng(cn, `ICT_OE_FIRST, 16'(n_q + 16'h0004));

    // ==========================================
    // Result capture for the cycle on the pins
    wire cap = is_int ? (c_q[0] && in_rng(c_q, 16'h0007, last)) :
               is_rd && in_rng(c_q, 16'h0006, last);
    wire [15:0] cw = is_int ? 16'((c_q - 16'h0007) >> 1) : 16'(c_q - 16'h0006);
    wire [31:0] expv = pat_q + {16'h0, cw};
    wire hit_win = is_kta && in_rng(c_q, `ICT_OE_FIRST, 16'(n_q + 16'h0004));
    wire running = (st_q == ict_pkg::ST_RUN);

    assign bus.test_addr = addr_q;
    assign bus.seq_ctrl = seq_q;
    assign bus.test_write_data_bus = data_q;
    assign bus.data_array_write_strobe = wr_q;
    assign bus.tag_write_strobe = tw_q;
    assign bus.data_array_read_strobe = rs_q;
    assign bus.tag_compare_strobe = kta_q;
    assign bus.read_output_enable = oe_q;
    // Test-mode controls held at their test values
    assign bus.test_mode_select = 1'b1;
    assign bus.integrated_memory_enable = 1'b1;
    assign bus.write_inhibit = 1'b0;
    assign bus.trace_select = 1'b0;
    assign bus.master_reset_n = mrst_q;

    // ==========================================
    // Sequencer next state
    always_comb begin
        st_d = st_q;
        c_d = 16'h0000;
        case (st_q)
            ict_pkg::ST_IDLE: begin
                if (start && ctl_wd[2:0] == ict_pkg::OP_ENTER) begin
                    st_d = ict_pkg::ST_RST;
                end else if (start && n_q != 16'h0000) begin
                    st_d = ict_pkg::ST_RUN;
                    c_d = 16'h0001;
                end
            end
            ict_pkg::ST_RST: begin
                if (cnt_q == `ICT_MRST_CYC - 4'h1) begin
                    st_d = ict_pkg::ST_STALL;
                end
            end
            ict_pkg::ST_STALL: begin
                if (cnt_q == `ICT_STALL_CYC - 4'h1) begin
                    st_d = ict_pkg::ST_IDLE;
                end
            end
            ict_pkg::ST_RUN: begin
                if (c_q == last) begin
                    st_d = ict_pkg::ST_IDLE;
                end else begin
                    c_d = 16'(c_q + 16'h0001);
                end
            end
            default: begin
                st_d = ict_pkg::ST_IDLE;
            end
        endcase
    end

    // Sequencer state and counters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= ict_pkg::ST_IDLE;
            c_q <= 16'h0000;
            cnt_q <= 4'h0;
            mrst_q <= 1'b1;
            rdy_q <= 1'b0;
        end else begin
            st_q <= st_d;
            c_q <= c_d;
            cnt_q <= (st_d == st_q && st_q != ict_pkg::ST_IDLE) ? cnt_q + 4'h1 : 4'h0;
            mrst_q <= (st_d != ict_pkg::ST_RST);
            if (st_d == ict_pkg::ST_RST) begin
                rdy_q <= 1'b0;
            end else if (st_q == ict_pkg::ST_STALL && st_d == ict_pkg::ST_IDLE) begin
                rdy_q <= 1'b1;
            end
        end
    end

    // Test bus outputs, all from flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_q <= 13'h0000;
            data_q <= 32'h0000_0000;
            {seq_q, wr_q, tw_q, rs_q, kta_q, oe_q} <= 6'h00;
        end else begin
            if (a_ok) begin
                addr_q <= 13'(base_q + ai[12:0]);
            end
            if (d_ok) begin
                data_q <= pat_q + {16'h0, di};
            end
            seq_q <= a_ok;
            {wr_q, tw_q, rs_q, kta_q, oe_q} <= {nx_wr, nx_tw, nx_rs, nx_kta, nx_oe};
        end
    end

    // Result counters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            err_q <= 32'h0000_0000;
            hits_q <= 32'h0000_0000;
            last_q <= 32'h0000_0000;
            done_q <= 1'b0;
        end else if (start) begin
            err_q <= 32'h0000_0000;
            hits_q <= 32'h0000_0000;
            done_q <= 1'b0;
        end else if (running) begin
            if (cap) begin
                last_q <= bus.test_read_data_bus;
                err_q <= err_q + {31'h0, bus.test_read_data_bus != expv};
            end
            if (hit_win) begin
                hits_q <= hits_q + {31'h0, bus.hit_flag};
            end
            done_q <= (c_q == last) || done_q;
        end
    end

    // ==========================================
    // AXI4-Lite write channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {awh_q, wh_q, bv_q} <= 3'h0;
            wa_q <= 8'h00;
            wd_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            br_q <= `ICT_RESP_OKAY;
            op_q <= ict_pkg::OP_WRITE;
            base_q <= 13'h0000;
            n_q <= 16'h0000;
            pat_q <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awh_q <= 1'b1;
                wa_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wh_q <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (do_wr) begin
                {awh_q, wh_q, bv_q} <= 3'h1;
                br_q <= w_map ? `ICT_RESP_OKAY : `ICT_RESP_SLVERR;
                if (start) begin
                    op_q <= ict_pkg::ict_op_e'(ctl_wd[2:0]);
                end
                if (wofs == `ICT_REG_ADDR && !busy) begin
                    base_q <= 13'(merge({19'h0, base_q}, wd_q, ws_q));
                end
                if (wofs == `ICT_REG_COUNT && !busy) begin
                    n_q <= 16'(merge({16'h0, n_q}, wd_q, ws_q));
                end
                if (wofs == `ICT_REG_PAT && !busy) begin
                    pat_q <= merge(pat_q, wd_q, ws_q);
                end
            end else if (bv_q && s_axi_bready) begin
                bv_q <= 1'b0;
            end
        end
    end

    // AXI4-Lite read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rv_q <= 1'b0;
            rd_q <= 32'h0000_0000;
            rr_q <= `ICT_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rv_q <= 1'b1;
            rd_q <= rmux;
            rr_q <= r_map ? `ICT_RESP_OKAY : `ICT_RESP_SLVERR;
        end else if (rv_q && s_axi_rready) begin
            rv_q <= 1'b0;
        end
    end
endmodule

// ### ict_properties.sv
// Purpose: Concurrent checks on the icache test bus
// Assumes: One clock domain, synchronous active-low reset
// Notes: Watches both ends through the interface signals
`timescale 1ns/1ps
module ict_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic seq_ctrl,
    input wire logic data_array_write_strobe,
    input wire logic data_array_read_strobe,
    input wire logic tag_compare_strobe,
    input wire logic read_output_enable,
    input wire logic master_reset_n,
    input wire logic hit_flag
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========================================
    // Test-mode entry steps
    sequence reset_hold;
        !master_reset_n [*6];
    endsequence
    sequence stall_quiet;
        (master_reset_n && !data_array_write_strobe && !data_array_read_strobe) [*8];
    endsequence
    a_entry_low: assert property ($fell(master_reset_n) |-> reset_hold)
        else $error("master reset shorter than six cycles");
    a_entry_stall: assert property ($rose(master_reset_n) |-> stall_quiet)
        else $error("strobe within eight cycles after master reset");
    a_reset_quiet: assert property (!master_reset_n |-> !data_array_write_strobe)
        else $error("write strobe during master reset");
    // ==========================================
    // Read pipeline ordering
    a_oe_cause: assert property ($rose(read_output_enable)
        |-> $past(data_array_read_strobe))
        else $error("output enable without prior read strobe");
    a_rd_then_oe: assert property ($rose(data_array_read_strobe) |=> read_output_enable)
        else $error("output enable not one cycle after read strobe");
    a_rd_addr_lead: assert property (($rose(data_array_read_strobe)
        && !$past(data_array_write_strobe)) |-> $past(seq_ctrl, 3))
        else $error("read strobe not three cycles after first address");
    a_cmp_with_rd: assert property (tag_compare_strobe |-> data_array_read_strobe)
        else $error("compare strobe without read strobe");
    a_inter_swap: assert property (($rose(data_array_read_strobe)
        && $past(data_array_write_strobe)) |-> !data_array_write_strobe
        ##1 (data_array_write_strobe && read_output_enable))
        else $error("interleaved strobe swap wrong");
    a_hit_cause: assert property (hit_flag |-> $past(tag_compare_strobe))
        else $error("hit flag outside compare reads");
endmodule

// ### test_icache_data_array_test_port.sv
// Purpose: Self-checking bench for both ends of the icache test port
// Assumes: Controller ordered over AXI4-Lite, results read back from registers
// Notes: Expected values queued by the driver, compared by the monitor
`timescale 1ns/1ps
`include "ict_cfg.svh"
module test_icache_data_array_test_port;
    localparam logic [31:0] all_m = 32'hFFFFFFFF;
    localparam logic [1:0] ok = `ICT_RESP_OKAY;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, seed, pat, q_d[$], q_m[$];
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, q_r[$], q_b[$];
    int miscompares, total_checks, cyc;
    // ==========================================
    // Both ends, joined by the interface
    ict_if bus ();
    ict_dev u_ict_dev (.aclk(aclk), .aresetn(aresetn), .bus(bus));
    ict_ctl u_ict_ctl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .bus(bus));
    ict_properties u_ict_properties (.aclk(aclk), .aresetn(aresetn), .seq_ctrl(bus.seq_ctrl),
        .data_array_write_strobe(bus.data_array_write_strobe),
        .data_array_read_strobe(bus.data_array_read_strobe),
        .tag_compare_strobe(bus.tag_compare_strobe),
        .read_output_enable(bus.read_output_enable),
        .master_reset_n(bus.master_reset_n), .hit_flag(bus.hit_flag));
    // ==========================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic chk2(input string n, input logic [1:0] e, input logic [1:0] s);
        total_checks++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // AXI write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge aclk);
        q_b.push_back(r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        do @(posedge aclk); while (!bvalid);
        bready <= 1'b0;
    endtask
    // AXI read, expectation masked
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
        input logic [1:0] r);
        @(posedge aclk);
        q_d.push_back(e & m);
        q_m.push_back(m);
        q_r.push_back(r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid);
        rready <= 1'b0;
    endtask
    // One test sequence, waits out its fixed length
    task automatic run(input logic [2:0] op, input logic [12:0] a, input logic [15:0] n,
        input logic [31:0] p);
        wr(`ICT_REG_ADDR, {19'h00000, a}, ok);
        wr(`ICT_REG_COUNT, {16'h0000, n}, ok);
        wr(`ICT_REG_PAT, p, ok);
        wr(`ICT_REG_CTRL, {29'h00000000, op}, ok);
        repeat (2 * n + 30) @(posedge aclk);
    endtask
    // ==========================================
    // Clock, monitor and timeout
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc++;
        if (bvalid && bready) chk2("bresp", q_b.pop_front(), bresp);
        if (rvalid && rready) begin
            chk32("rdata", q_d.pop_front(), rdata & q_m.pop_front());
            chk2("rresp", q_r.pop_front(), rresp);
        end
        if (cyc == 6000) begin
            miscompares++;
            report_and_stop();
        end
    end
    // ==========================================
    // Main sequence
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
        {awaddr, araddr, wdata, wstrb} = 52'h0000000000000 | 4'hF;
        {miscompares, total_checks, cyc} = 96'h0;
        seed = 32'h1BCE7254;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`ICT_REG_STAT, 32'h00000007, 32'h00000000, ok);
        wr(`ICT_REG_CTRL, {29'h00000000, ict_pkg::OP_ENTER}, ok);
        repeat (30) @(posedge aclk);
        rd(`ICT_REG_STAT, 32'h00000007, 32'h00000002, ok);
        pat = rnd() & 32'hFFFF8000;
        run(ict_pkg::OP_WRITE, 13'h007E, 16'h0006, pat);
        run(ict_pkg::OP_READ, 13'h007E, 16'h0006, pat);
        rd(`ICT_REG_ERR, all_m, 32'h00000000, ok);
        rd(`ICT_REG_LAST, all_m, pat + 32'h00000005, ok);
        run(ict_pkg::OP_READ, 13'h007E, 16'h0006, pat + 32'h00000001);
        rd(`ICT_REG_ERR, all_m, 32'h00000006, ok);
        pat = rnd() & 32'hFFFF8000;
        run(ict_pkg::OP_INTER, 13'h0040, 16'h0005, pat);
        rd(`ICT_REG_ERR, all_m, 32'h00000000, ok);
        rd(`ICT_REG_LAST, all_m, pat + 32'h00000004, ok);
        pat = rnd() & 32'hFFFF8000;
        run(ict_pkg::OP_WRITE, 13'h0010, 16'h0008, pat);
        run(ict_pkg::OP_TAGWR, 13'h0010, 16'h0008, pat);
        run(ict_pkg::OP_KTA, 13'h0010, 16'h0008, pat);
        rd(`ICT_REG_HITS, all_m, 32'h00000008, ok);
        rd(`ICT_REG_LAST, all_m, pat + 32'h00000007, ok);
        run(ict_pkg::OP_KTA, 13'h0010, 16'h0008, pat ^ 32'h80000000);
        rd(`ICT_REG_HITS, all_m, 32'h00000000, ok);
        wr(8'h20, rnd(), `ICT_RESP_SLVERR);
        rd(8'h20, all_m, 32'h00000000, `ICT_RESP_SLVERR);
        repeat (4) @(posedge aclk);
        report_and_stop();
    end
endmodule
